// *** option_byte_config.sv ***
// Purpose: latch and decode the two hardware option bytes into device settings
// Assumes: programming port is synchronous to ref_clk; prog_mode_pin is a pin
// Notes: cpu_cycle_en is the one-cycle cpu-rate enable from the clock divider
// How it works
// (R1) halt resets only when option set, watchdog active
// (R2) watchdog type: hardware always on, else software
// (R3) tool keeps reserved byte-zero bits at one
// (R4) protection blocks readout and flash writes
// (R5) protected option erase wipes user memory first
// (R6) package bit picks wide or narrow pads
// (R7) unbonded pads come up pulled-up inputs
// (R8) reset and halt exit last 4096 or 256
// (R9) resonators should use the long reset phase
// (R10) two-bit clock source decode
// (R11) no external clock with doubler on flash
// (R12) three-bit range field decode
// (R13) doubler on when its bypass bit is zero
// (R14) doubler only with two-to-four MHz range
// (R15) no doubler with internal rc source
// (R16) blank option bits read as one
// (R17) bytes reachable only in programming mode
// (R18) flash ships with internal rc source
// (R19) rom parts fix options, not programmable
// (R20) rom protection bit polarity inverted
// (R21) bytes latched in reset, held until next
`timescale 1ns/1ps
module option_byte_config
#(
   parameter bit IS_ROM = 1'b0, // masked rom part
   parameter logic [7:0] ROM_BYTE0 = 8'hFF, // rom-fixed byte zero
   parameter logic [7:0] ROM_BYTE1 = 8'hEF, // rom-fixed byte one
   parameter int NUM_PORTS = 6, // io ports, eight pads each
   parameter logic [47:0] BONDED_WIDE = 48'hFFFF_FFFF_FFFF, // pads bonded on 48/44 pins
   parameter logic [47:0] BONDED_NARROW = 48'h00FF_FFFF_FFFF // pads bonded on 32 pins
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic factory_init,
   input wire logic prog_mode_pin,
   input wire obc_pkg::obc_prog_req_t prog_req,
   output logic [7:0] prog_rdata,
   output logic prog_rvalid,
   output logic user_erase_req,
   input wire logic user_erase_done,
   input wire logic cpu_cycle_en,
   input wire logic halt_entry,
   input wire logic halt_wake,
   input wire logic watchdog_active,
   input wire logic mem_read_req,
   input wire logic flash_write_req,
   output logic mem_read_allow,
   output logic flash_write_allow,
   output logic halt_reset_req,
   output logic cpu_run,
   output logic halt_exit_done,
   output obc_pkg::obc_settings_t settings,
   output logic [NUM_PORTS*8-1:0] pad_pullup_force,
   output logic config_suspect
);
   import obc_pkg::*;

   // refuse port counts that the 48-pad bond masks cannot serve
   if (NUM_PORTS < 1 || NUM_PORTS > 6)
   begin : g_bad_ports
      $error("option_byte_config: NUM_PORTS must be 1 to 6");
   end

   // phase and erase state machines
   typedef enum logic [1:0] {PH_RESET, PH_RUN, PH_HALT_EXIT} obc_phase_t;
   typedef enum logic [1:0] {ER_IDLE, ER_WIPE, ER_OPT} obc_erase_t;

   logic mode_meta; // first synchroniser stage
   logic mode_sync; // programming mode, synchronised
   logic [7:0] store_b0; // stored byte zero
   logic [7:0] store_b1; // stored byte one
   logic [7:0] src_b0; // effective byte zero (rom or flash)
   logic [7:0] src_b1; // effective byte one
   logic [7:0] latch_b0; // byte zero latched at reset
   logic [7:0] latch_b1; // byte one latched at reset
   logic [7:0] next_latch_b0;
   logic [7:0] next_latch_b1;
   logic protect_now; // protection in stored bytes
   logic store_wr; // write into storage
   logic store_erase; // erase into storage
   obc_erase_t erase_state;
   obc_erase_t next_erase_state;
   obc_phase_t phase;
   obc_phase_t next_phase;
   logic [OBC_CNT_W-1:0] phase_cnt; // cpu cycles left
   logic [OBC_CNT_W-1:0] next_phase_cnt;
   logic [OBC_CNT_W-1:0] phase_len; // length from latched option
   logic [7:0] next_prog_rdata;
   logic next_prog_rvalid;
   logic next_halt_exit_done;

   // protection bit meaning depends on part type
   function automatic logic protect_of(input logic [7:0] b0);
      if (IS_ROM)
         protect_of = b0[OBC_B0_PROTECT]; // R20
      else
         protect_of = ~b0[OBC_B0_PROTECT]; // R20
   endfunction : protect_of

   // programming-mode pin synchroniser
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         mode_meta <= 1'b0;
         mode_sync <= 1'b0;
      end
      else
      begin
         mode_meta <= prog_mode_pin;
         mode_sync <= mode_meta;
      end
   end

   // rom parts ignore programming-port writes and erases; reads still return the rom bytes
   assign store_wr = mode_sync & prog_req.wr & ~IS_ROM & (erase_state == ER_IDLE); // R17 R19
   assign store_erase = (erase_state == ER_OPT); // R16

   // non-volatile option bytes
   obc_nv_store u_store
   (
      .ref_clk(ref_clk),
      .factory_init(factory_init),
      .wr_en(store_wr),
      .wr_sel(prog_req.sel),
      .wr_data(prog_req.wdata),
      .erase_en(store_erase),
      .byte0(store_b0),
      .byte1(store_b1)
   );

   // rom parts take the hardwired code
   assign src_b0 = IS_ROM ? ROM_BYTE0 : store_b0; // R19
   assign src_b1 = IS_ROM ? ROM_BYTE1 : store_b1; // R19
   assign protect_now = protect_of(src_b0);

   // option erase sequencing
   always_comb
   begin
      next_erase_state = erase_state;
      case (erase_state)
         ER_IDLE:
         begin
            if (mode_sync && prog_req.erase && !IS_ROM)
            begin
               // protected: wipe user memory before the bytes
               if (protect_now)
                  next_erase_state = ER_WIPE; // R5
               else
                  next_erase_state = ER_OPT;
            end
         end
         ER_WIPE:
         begin
            if (user_erase_done)
               next_erase_state = ER_OPT; // R5
         end
         ER_OPT:
            next_erase_state = ER_IDLE;
         default:
            next_erase_state = ER_IDLE;
      endcase
   end

   // erase state register
   always_ff @(posedge ref_clk)
   begin
      if (reset)
         erase_state <= ER_IDLE;
      else
         erase_state <= next_erase_state;
   end

   assign user_erase_req = (erase_state == ER_WIPE); // R5

   // readback only in programming mode
   always_comb
   begin
      next_prog_rvalid = mode_sync & prog_req.rd; // R17
      next_prog_rdata = prog_rdata;
      if (mode_sync && prog_req.rd)
         next_prog_rdata = (prog_req.sel == OBC_SEL_BYTE1) ? src_b1 : src_b0; // R17
   end

   // readback registers
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         prog_rdata <= 8'h00;
         prog_rvalid <= 1'b0;
      end
      else
      begin
         prog_rdata <= next_prog_rdata;
         prog_rvalid <= next_prog_rvalid;
      end
   end

   // sample the bytes while reset is held, freeze afterwards
   always_comb
   begin
      next_latch_b0 = latch_b0;
      next_latch_b1 = latch_b1;
      if (reset)
      begin
         next_latch_b0 = src_b0; // R21
         next_latch_b1 = src_b1; // R21
      end
   end

   // latched bytes
   always_ff @(posedge ref_clk)
   begin
      latch_b0 <= next_latch_b0;
      latch_b1 <= next_latch_b1;
   end

   // decode of the latched bytes
   always_comb
   begin
      settings.halt_reset_en = latch_b0[OBC_B0_HALT_RST]; // R1
      settings.hw_watchdog = ~latch_b0[OBC_B0_WDG_TYPE]; // R2
      settings.readout_protect = protect_of(latch_b0); // R4
      settings.pkg_wide = latch_b1[OBC_B1_PKG]; // R6
      settings.short_reset = latch_b1[OBC_B1_RST_CYC]; // R8
      settings.clk_src = latch_b1[OBC_B1_SRC_HI:OBC_B1_SRC_LO]; // R10
      settings.freq_range = latch_b1[OBC_B1_RANGE_HI:OBC_B1_RANGE_LO]; // R12
      settings.pll_enable = ~latch_b1[OBC_B1_PLL_OFF]; // R13
   end

   // halt reset request
   assign halt_reset_req = halt_entry & watchdog_active & settings.halt_reset_en; // R1

   // protection gates readout and flash writes outside programming
   assign mem_read_allow = mem_read_req & ~settings.readout_protect; // R4
   assign flash_write_allow = flash_write_req & ~settings.readout_protect; // R4

   // pull-ups on every pad the package leaves unbonded
   genvar gp;
   generate
      for (gp = 0; gp < NUM_PORTS; gp++)
      begin : g_port
         assign pad_pullup_force[gp*8 +: 8] = settings.pkg_wide
            ? ~BONDED_WIDE[gp*8 +: 8] : ~BONDED_NARROW[gp*8 +: 8]; // R6 R7
      end
   endgenerate

   // flag combinations the tool should never program
   always_comb
   begin
      config_suspect = 1'b0;
      if (~&latch_b0[OBC_B0_CLK_SEC:OBC_B0_RSV_LO])
         config_suspect = 1'b1; // R3
      if (settings.clk_src == OBC_SRC_RESERVED)
         config_suspect = 1'b1; // R10
      if (settings.pll_enable && settings.clk_src == OBC_SRC_EXTERNAL && !IS_ROM)
         config_suspect = 1'b1; // R11
      if (settings.pll_enable && settings.freq_range != OBC_RANGE_2_TO_4MHZ)
         config_suspect = 1'b1; // R14
      if (settings.pll_enable && settings.clk_src == OBC_SRC_RC)
         config_suspect = 1'b1; // R15
      if (settings.clk_src == OBC_SRC_RESONATOR && settings.short_reset)
         config_suspect = 1'b1; // R9
   end

   // phase length from the latched option
   assign phase_len = settings.short_reset ? OBC_RST_SHORT : OBC_RST_LONG; // R8

   // reset phase and halt exit timer
   always_comb
   begin
      next_phase = phase;
      next_phase_cnt = phase_cnt;
      next_halt_exit_done = 1'b0;
      case (phase)
         PH_RESET, PH_HALT_EXIT:
         begin
            if (cpu_cycle_en)
            begin
               if (phase_cnt == OBC_CNT_W'(1))
               begin
                  next_halt_exit_done = (phase == PH_HALT_EXIT); // R8
                  next_phase = PH_RUN;
               end
               next_phase_cnt = phase_cnt - OBC_CNT_W'(1);
            end
         end
         PH_RUN:
         begin
            if (halt_wake)
            begin
               next_phase = PH_HALT_EXIT;
               next_phase_cnt = phase_len; // R8
            end
         end
         default:
            next_phase = PH_RUN;
      endcase
   end

   // phase registers; reset loads the length from the bytes being latched
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         phase <= PH_RESET;
         phase_cnt <= src_b1[OBC_B1_RST_CYC] ? OBC_RST_SHORT : OBC_RST_LONG; // R8
         halt_exit_done <= 1'b0;
      end
      else
      begin
         phase <= next_phase;
         phase_cnt <= next_phase_cnt;
         halt_exit_done <= next_halt_exit_done;
      end
   end

   assign cpu_run = (phase == PH_RUN);

   // checks
   logic [OBC_CNT_W:0] run_cnt; // cpu cycles spent in the reset phase since reset release
   logic past_valid; // one edge after reset
   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         run_cnt <= '0;
         past_valid <= 1'b0;
      end
      else
      begin
         past_valid <= 1'b1;
         if (cpu_cycle_en && phase == PH_RESET)
            run_cnt <= run_cnt + (OBC_CNT_W+1)'(1);
      end
   end

   chk_halt_reset_gate: assert property (@(posedge ref_clk) disable iff (reset)
      halt_reset_req |-> (halt_entry && watchdog_active && latch_b0[OBC_B0_HALT_RST]))
      else $error("halt reset without option or active watchdog"); // R1
   chk_watchdog_type: assert property (@(posedge ref_clk) disable iff (reset)
      settings.hw_watchdog == !latch_b0[OBC_B0_WDG_TYPE])
      else $error("watchdog type decode wrong"); // R2
   chk_protect_blocks: assert property (@(posedge ref_clk) disable iff (reset)
      settings.readout_protect |-> !mem_read_allow && !flash_write_allow)
      else $error("protected part allowed access"); // R4
   chk_wipe_before_opt: assert property (@(posedge ref_clk) disable iff (reset)
      (erase_state == ER_IDLE && mode_sync && prog_req.erase && !IS_ROM && protect_now)
      |=> user_erase_req && !store_erase)
      else $error("protected erase skipped user wipe"); // R5
   chk_reset_length: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(cpu_run) && !halt_exit_done && phase != PH_HALT_EXIT && run_cnt != 0
      |-> run_cnt == {1'b0, phase_len})
      else $error("reset phase length wrong"); // R8
   chk_halt_exit_len: assert property (@(posedge ref_clk) disable iff (reset)
      (phase == PH_RUN && halt_wake && settings.short_reset && cpu_cycle_en)
      ##1 (cpu_cycle_en && phase == PH_HALT_EXIT) [*8] |-> !halt_exit_done)
      else $error("halt exit ended too early"); // R8
   chk_pll_decode: assert property (@(posedge ref_clk) disable iff (reset)
      settings.pll_enable == !latch_b1[OBC_B1_PLL_OFF]
      && settings.clk_src == latch_b1[OBC_B1_SRC_HI:OBC_B1_SRC_LO])
      else $error("clock decode wrong"); // R13
   chk_no_access_out: assert property (@(posedge ref_clk) disable iff (reset)
      !mode_sync |=> !prog_rvalid && $stable(store_b0) || factory_init)
      else $error("option bytes touched outside programming mode"); // R17
   chk_latch_hold: assert property (@(posedge ref_clk) disable iff (reset)
      past_valid |-> $stable(latch_b0) && $stable(latch_b1))
      else $error("latched options changed after reset"); // R21
endmodule : option_byte_config

// *** obc_pkg.sv ***
// Purpose: shared constants and carriers for the option byte configuration block
// Assumes: one clock, synchronous active-high reset
// Notes: bit positions follow the two eight-bit option bytes
package obc_pkg;
   // erased and factory contents
   localparam logic [7:0] OBC_BYTE_ERASED = 8'hFF; // blank flash reads all ones
   localparam logic [7:0] OBC_BYTE1_FACTORY = 8'hEF; // internal rc source, rest ones
   // byte zero fields
   localparam int OBC_B0_HALT_RST = 7; // halt_watchdog_reset_opt
   localparam int OBC_B0_WDG_TYPE = 6; // watchdog_type_select
   localparam int OBC_B0_CLK_SEC = 5; // clock_security_opt
   localparam int OBC_B0_VDET_HI = 4; // voltage_detect_field msb
   localparam int OBC_B0_VDET_LO = 3; // voltage_detect_field lsb
   localparam int OBC_B0_RSV_HI = 2; // reserved pair msb
   localparam int OBC_B0_RSV_LO = 1; // reserved pair lsb
   localparam int OBC_B0_PROTECT = 0; // readout_protect_opt
   // byte one fields
   localparam int OBC_B1_PKG = 7; // package_select_opt
   localparam int OBC_B1_RST_CYC = 6; // reset_cycle_select
   localparam int OBC_B1_SRC_HI = 5; // clock_source_type msb
   localparam int OBC_B1_SRC_LO = 4; // clock_source_type lsb
   localparam int OBC_B1_RANGE_HI = 3; // osc_frequency_range msb
   localparam int OBC_B1_RANGE_LO = 1; // osc_frequency_range lsb
   localparam int OBC_B1_PLL_OFF = 0; // doubler bypass
   // clock source codes
   localparam logic [1:0] OBC_SRC_RESONATOR = 2'h0;
   localparam logic [1:0] OBC_SRC_RESERVED = 2'h1;
   localparam logic [1:0] OBC_SRC_RC = 2'h2;
   localparam logic [1:0] OBC_SRC_EXTERNAL = 2'h3;
   // frequency range codes
   localparam logic [2:0] OBC_RANGE_1_TO_2MHZ = 3'h0;
   localparam logic [2:0] OBC_RANGE_2_TO_4MHZ = 3'h1;
   localparam logic [2:0] OBC_RANGE_4_TO_8MHZ = 3'h2;
   localparam logic [2:0] OBC_RANGE_8_TO_16MHZ = 3'h3;
   // reset phase lengths in cpu cycles
   localparam int OBC_CNT_W = 13;
   localparam logic [12:0] OBC_RST_LONG = 13'h1000; // 4096 cycles
   localparam logic [12:0] OBC_RST_SHORT = 13'h0100; // 256 cycles
   // byte selectors on the programming port
   localparam logic OBC_SEL_BYTE0 = 1'b0;
   localparam logic OBC_SEL_BYTE1 = 1'b1;
   // request from the programming tool
   typedef struct packed {
      logic rd; // read strobe
      logic wr; // write strobe
      logic erase; // erase both bytes
      logic sel; // byte selector
      logic [7:0] wdata; // write data
   } obc_prog_req_t;
   // decoded settings
   typedef struct packed {
      logic halt_reset_en; // reset on halt while watchdog runs
      logic hw_watchdog; // watchdog forced on
      logic readout_protect; // protection active
      logic pkg_wide; // 48/44-pin pad set
      logic short_reset; // 256-cycle reset phase
      logic [1:0] clk_src; // main clock source
      logic [2:0] freq_range; // range or drive
      logic pll_enable; // times-two doubler on
   } obc_settings_t;
endpackage : obc_pkg

// *** obc_nv_store.sv ***
// Purpose: the two non-volatile option bytes
// Assumes: contents survive reset; factory_init models shipping contents
// Notes: erase wins over write in the same cycle
`timescale 1ns/1ps
module obc_nv_store
(
   input wire logic ref_clk,
   input wire logic factory_init,
   input wire logic wr_en,
   input wire logic wr_sel,
   input wire logic [7:0] wr_data,
   input wire logic erase_en,
   output logic [7:0] byte0,
   output logic [7:0] byte1
);
   import obc_pkg::*;
   logic [7:0] next_byte0; // next contents of byte zero
   logic [7:0] next_byte1; // next contents of byte one

   // next contents: init, erase, then write
   always_comb
   begin
      next_byte0 = byte0;
      next_byte1 = byte1;
      if (factory_init)
      begin
         // shipped with rc clock for in-circuit programming
         next_byte0 = OBC_BYTE_ERASED; // R18
         next_byte1 = OBC_BYTE1_FACTORY; // R18
      end
      else if (erase_en)
      begin
         next_byte0 = OBC_BYTE_ERASED; // R16
         next_byte1 = OBC_BYTE_ERASED; // R16
      end
      else if (wr_en)
      begin
         if (wr_sel == OBC_SEL_BYTE1)
            next_byte1 = wr_data;
         else
            next_byte0 = wr_data;
      end
   end

   // storage cells, no reset: they are non-volatile
   always_ff @(posedge ref_clk)
   begin
      byte0 <= next_byte0;
      byte1 <= next_byte1;
   end
endmodule : obc_nv_store

// *** obc_prog_tool.sv ***
// Purpose: programming tool model driving the option byte port
// Assumes: tool runs on ref_clk, strobes last one cycle
// Notes: fix_b0 and fix_b1 make bytes legal except a reserved clock source, which stays; send writes bytes as given
`timescale 1ns/1ps
module obc_prog_tool
(
   input wire logic ref_clk,
   output logic prog_mode_pin,
   output obc_pkg::obc_prog_req_t prog_req
);
   import obc_pkg::*;
   // idle tool, not in programming mode
   initial
   begin
      prog_mode_pin = 1'b0;
      prog_req = '0;
   end
   // reserved byte-zero bits stay at one
   function automatic logic [7:0] fix_b0(input logic [7:0] b);
      fix_b0 = b | 8'h3E;
   endfunction : fix_b0
   // avoid doubler and reset-length settings that are unsupported or advised against; the source field is kept
   function automatic logic [7:0] fix_b1(input logic [7:0] b);
      logic [7:0] r;
      r = b;
      if (r[5:4] == OBC_SRC_RESONATOR)
         r[6] = 1'b0;
      // rc or external source, or wrong range: doubler stays bypassed
      if (r[5] || r[3:1] != OBC_RANGE_2_TO_4MHZ)
         r[0] = 1'b1;
      fix_b1 = r;
   endfunction : fix_b1
   // one request, strobes held for one edge
   task automatic send(input logic rd, wr, er, sel, input logic [7:0] d);
      @(posedge ref_clk);
      prog_req <= '{rd: rd, wr: wr, erase: er, sel: sel, wdata: d};
      @(posedge ref_clk);
      prog_req <= '0;
   endtask : send
   // mode pin, then wait out the synchroniser
   task automatic set_mode(input logic on);
      @(posedge ref_clk);
      prog_mode_pin <= on;
      repeat (3) @(posedge ref_clk);
   endtask : set_mode
endmodule : obc_prog_tool

// *** option_byte_config_bench.sv ***
// Purpose: self-checking bench for the option byte configuration block
// Assumes: cpu_cycle_en high every cycle to shorten reset phases
// Notes: readback expectations queue up and are checked on prog_rvalid
`timescale 1ns/1ps
module option_byte_config_bench;
   import obc_pkg::*;
   localparam logic [47:0] WIDE = 48'hFFFF_FFFF_FFFF; // all pads bonded
   localparam logic [47:0] NARROW = 48'h00FF_FFFF_FFFF; // top port unbonded
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic factory_init = 1'b1;
   logic user_erase_done = 1'b0;
   logic cpu_cycle_en = 1'b1;
   logic halt_entry = 1'b0;
   logic halt_wake = 1'b0;
   logic watchdog_active = 1'b0;
   logic mem_read_req = 1'b0;
   logic flash_write_req = 1'b0;
   logic prog_mode_pin, prog_rvalid, user_erase_req, mem_read_allow, flash_write_allow;
   logic halt_reset_req, cpu_run, halt_exit_done, config_suspect;
   logic [7:0] prog_rdata;
   logic [47:0] pad_pullup_force;
   obc_prog_req_t prog_req;
   obc_settings_t settings;
   int errors = 0;
   int checks = 0;
   logic [31:0] seed = 32'h0001_66B2; // 91826
   logic [7:0] exp_q[$]; // expected readback bytes
   // free-running clock
   always #5 ref_clk = ~ref_clk;
   obc_prog_tool tool (.ref_clk, .prog_mode_pin, .prog_req);
   option_byte_config #(.BONDED_WIDE(WIDE), .BONDED_NARROW(NARROW)) dut
   (
      .ref_clk, .reset, .factory_init, .prog_mode_pin, .prog_req, .prog_rdata,
      .prog_rvalid, .user_erase_req, .user_erase_done, .cpu_cycle_en, .halt_entry,
      .halt_wake, .watchdog_active, .mem_read_req, .flash_write_req, .mem_read_allow,
      .flash_write_allow, .halt_reset_req, .cpu_run, .halt_exit_done, .settings,
      .pad_pullup_force, .config_suspect
   );
   // xorshift source
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      rnd = seed;
   endfunction : rnd
   // expected settings from the two bytes
   function automatic obc_settings_t decode(input logic [7:0] b0, b1);
      decode = '{halt_reset_en: b0[7], hw_watchdog: !b0[6], readout_protect: !b0[0],
         pkg_wide: b1[7], short_reset: b1[6], clk_src: b1[5:4], freq_range: b1[3:1],
         pll_enable: !b1[0]};
   endfunction : decode
   // reset phase length in cpu cycles
   function automatic int cnt(input logic [7:0] b1);
      cnt = b1[6] ? int'(OBC_RST_SHORT) : int'(OBC_RST_LONG);
   endfunction : cnt
   task automatic check(input string what, input logic [47:0] seen, exp);
      checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   // readback monitor, oldest note first
   always @(posedge ref_clk)
      if (prog_rvalid === 1'b1)
      begin
         if (exp_q.size() == 0)
            check("spurious readback", 48'h1, 48'h0);
         else
            check("readback", prog_rdata, exp_q.pop_front());
      end
   task automatic rd_byte(input logic sel, input logic [7:0] exp);
      exp_q.push_back(exp);
      tool.send(1'b1, 1'b0, 1'b0, sel, 8'h00);
   endtask : rd_byte
   // reset, then time the reset phase
   task automatic do_reset(input logic [7:0] b1);
      int n;
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      n = 0;
      while (cpu_run !== 1'b1 && n < 5000)
      begin
         @(negedge ref_clk);
         n++;
      end
      check("reset phase", 48'(n >= cnt(b1) && n <= cnt(b1) + 4), 48'h1);
   endtask : do_reset
   // random halt and access requests against the latched options
   task automatic live(input obc_settings_t s);
      repeat (8)
      begin
         @(posedge ref_clk);
         {halt_entry, watchdog_active, mem_read_req, flash_write_req} <= 4'(rnd());
         @(negedge ref_clk);
         check("halt reset", halt_reset_req, halt_entry & watchdog_active & s.halt_reset_en);
         check("read allow", mem_read_allow, mem_read_req & !s.readout_protect);
         check("write allow", flash_write_allow, flash_write_req & !s.readout_protect);
      end
      @(posedge ref_clk);
      halt_entry <= 1'b0;
   endtask : live
   // halt exit delay matches the reset phase
   task automatic halt_exit(input logic [7:0] b1);
      int n;
      @(posedge ref_clk);
      halt_wake <= 1'b1;
      @(posedge ref_clk);
      halt_wake <= 1'b0;
      n = 0;
      while (halt_exit_done !== 1'b1 && n < 5000)
      begin
         @(negedge ref_clk);
         n++;
      end
      check("halt exit", 48'(n >= cnt(b1) - 1 && n <= cnt(b1) + 4), 48'h1);
   endtask : halt_exit
   // hang guard
   initial
   begin
      #700_000;
      errors++;
      finish_test();
   end
   // main sequence
   initial
   begin
      logic [7:0] b0;
      logic [7:0] b1;
      int n;
      obc_settings_t s;
      repeat (2) @(posedge ref_clk);
      factory_init <= 1'b0;
      b1 = OBC_BYTE1_FACTORY;
      do_reset(b1);
      s = decode(OBC_BYTE_ERASED, b1);
      check("factory settings", settings, s);
      // requests outside programming mode are refused
      tool.send(1'b0, 1'b1, 1'b0, OBC_SEL_BYTE1, 8'h00);
      tool.send(1'b1, 1'b0, 1'b0, OBC_SEL_BYTE1, 8'h00);
      tool.set_mode(1'b1);
      rd_byte(OBC_SEL_BYTE1, OBC_BYTE1_FACTORY);
      $display("test refusal done");
      for (int src = 0; src < 4; src++)
      begin
         b0 = tool.fix_b0(8'(rnd()));
         b1 = 8'(rnd());
         b1[5:4] = 2'(src);
         b1[3] = 1'b0;
         b1 = tool.fix_b1(b1);
         tool.send(1'b0, 1'b1, 1'b0, OBC_SEL_BYTE0, b0);
         tool.send(1'b0, 1'b1, 1'b0, OBC_SEL_BYTE1, b1);
         rd_byte(OBC_SEL_BYTE0, b0);
         rd_byte(OBC_SEL_BYTE1, b1);
         check("held settings", settings, s);
         s = decode(b0, b1);
         do_reset(b1);
         check("settings", settings, s);
         check("pull-ups", pad_pullup_force, ~(s.pkg_wide ? WIDE : NARROW));
         check("suspect", config_suspect, 48'(b1[5:4] == OBC_SRC_RESERVED));
         live(s);
         halt_exit(b1);
         $display("test config %0d done", src);
      end
      // protected part, external clock with doubler on: flagged as suspect
      tool.send(1'b0, 1'b1, 1'b0, OBC_SEL_BYTE0, 8'hFE);
      tool.send(1'b0, 1'b1, 1'b0, OBC_SEL_BYTE1, 8'h72);
      do_reset(8'h72);
      check("protected settings", settings, decode(8'hFE, 8'h72));
      check("suspect external", config_suspect, 48'h1);
      live(decode(8'hFE, 8'h72));
      // protected option erase wipes user memory first
      tool.send(1'b0, 1'b0, 1'b1, OBC_SEL_BYTE0, 8'h00);
      n = 0;
      while (user_erase_req !== 1'b1 && n < 10)
      begin
         @(negedge ref_clk);
         n++;
      end
      check("wipe request", user_erase_req, 48'h1);
      @(posedge ref_clk);
      user_erase_done <= 1'b1;
      @(posedge ref_clk);
      user_erase_done <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd_byte(OBC_SEL_BYTE0, OBC_BYTE_ERASED);
      rd_byte(OBC_SEL_BYTE1, OBC_BYTE_ERASED);
      $display("test protected erase done");
      // unprotected erase needs no wipe
      do_reset(OBC_BYTE_ERASED);
      tool.send(1'b0, 1'b1, 1'b0, OBC_SEL_BYTE1, tool.fix_b1(8'(rnd())));
      tool.send(1'b0, 1'b0, 1'b1, OBC_SEL_BYTE1, 8'h00);
      @(negedge ref_clk);
      check("no wipe", user_erase_req, 48'h0);
      repeat (3) @(posedge ref_clk);
      rd_byte(OBC_SEL_BYTE1, OBC_BYTE_ERASED);
      repeat (3) @(posedge ref_clk);
      check("pending reads", 48'(exp_q.size()), 48'h0);
      $display("test plain erase done");
      finish_test();
   end
endmodule : option_byte_config_bench
